// File: design/pin_edge_detect.v
// Purpose: Synchronise an external count pin and detect its edges.
// Assumes: Pin is asynchronous to aclk.
// Notes:   Two synchroniser stages, a hold stage standing in for the half-cycle latch,
//          then edge compare; pulses are one cycle wide.
`timescale 1ns/1ps

module pin_edge_detect
(
	// Clock and reset
	input  wire aclk,
	input  wire aresetn,
	// Pin
	input  wire count_pin,
	// Edge pulses
	output wire rise_pulse,
	output wire fall_pulse
);

	reg sync_first;  // First synchroniser stage, read only by sync_second
	reg sync_second; // Second synchroniser stage
	reg sampled;     // Latched sample, one cycle behind

	// Sample once per cycle through the chain
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sync_first  <= 1'b0;
			sync_second <= 1'b0;
			sampled     <= 1'b0;
		end
		else
		begin
			sync_first  <= count_pin;
			sync_second <= sync_first;
			sampled     <= sync_second;
		end
	end

	// One pulse per edge seen between adjacent samples
	assign rise_pulse = sync_second & ~sampled;
	assign fall_pulse = ~sync_second & sampled;

endmodule

// File: design/tick_prescaler.v
// Purpose: Free-running prescaler shared by both timers, with four tap pulses.
// Assumes: One clock; clear is a one-cycle pulse from the register block.
// Notes:   Taps fire once every 8, 64, 256 and 1024 cycles.
`timescale 1ns/1ps
`include "timer8_map.vh"

module tick_prescaler
(
	// Clock and reset
	input  wire       aclk,
	input  wire       aresetn,
	// Control
	input  wire       prescaler_clear,
	// Tap pulses: bit 0 div 8, 1 div 64, 2 div 256, 3 div 1024
	output wire [3:0] tap_pulses
);

	reg [`PRESCALER_WIDTH-1:0] phase; // Free-running count

	// Runs regardless of any clock select; only reset or a clear restarts it
	always @(posedge aclk)
	begin
		if (!aresetn || prescaler_clear)
			phase <= {`PRESCALER_WIDTH{1'b0}};
		else
			phase <= phase + 1'b1;
	end

	// Taps are the cycles where the low bits are all ones
	assign tap_pulses[0] = (phase & `TAP_MASK_DIV8) == `TAP_MASK_DIV8;
	assign tap_pulses[1] = (phase & `TAP_MASK_DIV64) == `TAP_MASK_DIV64;
	assign tap_pulses[2] = (phase & `TAP_MASK_DIV256) == `TAP_MASK_DIV256;
	assign tap_pulses[3] = (phase & `TAP_MASK_DIV1024) == `TAP_MASK_DIV1024;

endmodule

// File: design/timer8_map.vh
// Purpose: Register offsets, field positions, reset values and codes of the 8-bit timer.
// Assumes: Included by the prescaler and register block design files; definitions only.
// Notes:   Byte addresses on a 32-bit AXI4-Lite bus, one register per aligned word.
`ifndef TIMER8_MAP_VH
`define TIMER8_MAP_VH

// Register byte offsets
`define OFS_COUNTER_VALUE    6'h00
`define OFS_COMPARE_VALUE    6'h04
`define OFS_IRQ_MASK         6'h08
`define OFS_IRQ_FLAGS        6'h0c
`define OFS_TIMER_CONTROL    6'h10
`define OFS_PRESCALER_CTRL   6'h14

// Field positions
`define BIT_COMPARE          0
`define BIT_OVERFLOW         1
`define BIT_PRESCALER_RESET  0
`define CS0_LSB              0
`define MODE_LSB             3
`define CS1_LSB              8

// Reset values
`define RST_COUNTER_VALUE    8'h00
`define RST_COMPARE_VALUE    8'h00
`define RST_IRQ_MASK         8'h00
`define RST_IRQ_FLAGS        8'h00
`define RST_CLOCK_SELECT     3'h0
`define RST_MODE             2'h0

// Clock source select codes
`define CS_STOPPED           3'h0
`define CS_DIRECT            3'h1
`define CS_DIV8              3'h2
`define CS_DIV64             3'h3
`define CS_DIV256            3'h4
`define CS_DIV1024           3'h5
`define CS_EXT_FALL          3'h6
`define CS_EXT_RISE          3'h7

// Counting modes
`define MODE_NORMAL          2'h0
`define MODE_PHASE_CORRECT   2'h1
`define MODE_CLEAR_ON_MATCH  2'h2
`define MODE_FAST            2'h3

// Prescaler taps: a tap fires when these low counter bits are all ones
`define PRESCALER_WIDTH      10
`define TAP_MASK_DIV8        10'h007
`define TAP_MASK_DIV64       10'h03f
`define TAP_MASK_DIV256      10'h0ff
`define TAP_MASK_DIV1024     10'h3ff

// Counter limits and bus answers
`define COUNT_MAX            8'hff
`define COUNT_BOTTOM         8'h00
`define RESP_OKAY            2'h0
`define RESP_SLVERR          2'h2

`endif

// File: design/timer8_regs.v
// Purpose: 8-bit timer with compare, overflow/compare flags, shared prescaler
//          and external count pins, reached over AXI4-Lite.
// Assumes: aclk at 10 MHz, synchronous active-low reset, core supplies the
//          global interrupt enable and vector-taken pulses.
// Notes:   A second timer's clock-select path is kept here so both share the prescaler.
// Contract
// - Counter value readable and writable any time
// - Counter write blocks compare at next tick
// - Compare value continuously compared with counter
// - Overflow irq needs enable bit1, global, flag
// - Compare irq needs enable bit0, global, flag
// - Overflow flag bit1 set on counter overflow
// - Phase correct sets overflow at bottom reversal
// - Compare flag bit0 set on match
// - Taken vector clears its flag
// - Writing one clears flag; zero ignored
// - Two timers share prescaler, separate selects
// - Select 1 counts every clock
// - Prescaler taps divide by 8,64,256,1024
// - Prescaler free runs, ignores clock selects
// - Prescaled start latency 1 to N+1
// - Prescaler reset restarts phase for both
// - Pin sampled through sync then latch stage
// - One tick per rising or falling edge
// - Pin edge reaches counter within 2.5-3.5
// - Select 0 stops, 1-5 internal, 6-7 pin
// - Prescaler reset bit self-clears, reads zero
`timescale 1ns/1ps
`include "timer8_map.vh"

module timer8_regs
(
	// Clock and reset
	input  wire        aclk,
	input  wire        aresetn,
	// AXI4-Lite write address
	input  wire [5:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	// AXI4-Lite write data
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	// AXI4-Lite write response
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// AXI4-Lite read address
	input  wire [5:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	// AXI4-Lite read data
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// Core interrupt interface
	input  wire        global_irq_enable,
	input  wire        overflow_vector_taken,
	input  wire        compare_vector_taken,
	output reg         overflow_irq,
	output reg         compare_irq,
	// Pins
	input  wire        external_count_pin,
	input  wire        second_count_pin,
	output reg         compare_output_pin,
	// Tick enables
	output reg         timer_tick_enable,
	output reg         second_tick_enable
);

	// Decoded register selector, one bit per register, zero when unmapped
	function [5:0] reg_decode;
		input [5:0] addr;
		begin
			case (addr)
				`OFS_COUNTER_VALUE:  reg_decode = 6'h01;
				`OFS_COMPARE_VALUE:  reg_decode = 6'h02;
				`OFS_IRQ_MASK:       reg_decode = 6'h04;
				`OFS_IRQ_FLAGS:      reg_decode = 6'h08;
				`OFS_TIMER_CONTROL:  reg_decode = 6'h10;
				`OFS_PRESCALER_CTRL: reg_decode = 6'h20;
				default:             reg_decode = 6'h00;
			endcase
		end
	endfunction

	// Pick the tick for a clock select code
	function pick_tick;
		input [2:0] sel;
		input [3:0] taps;
		input       rise;
		input       fall;
		begin
			case (sel)
				`CS_STOPPED:  pick_tick = 1'b0;
				`CS_DIRECT:   pick_tick = 1'b1;
				`CS_DIV8:     pick_tick = taps[0];
				`CS_DIV64:    pick_tick = taps[1];
				`CS_DIV256:   pick_tick = taps[2];
				`CS_DIV1024:  pick_tick = taps[3];
				`CS_EXT_FALL: pick_tick = fall;
				default:      pick_tick = rise;
			endcase
		end
	endfunction

	// Merge a byte-lane-0 write into an 8-bit register
	function [7:0] merge_low;
		input [7:0]  old;
		input [31:0] data;
		input [3:0]  strb;
		begin
			merge_low = strb[0] ? data[7:0] : old;
		end
	endfunction

	// Register state
	reg  [7:0]  counter_value;        // Live counter
	reg  [7:0]  compare_value;        // Compare reference
	reg  [7:0]  timer_interrupt_mask; // Enable bits
	reg  [7:0]  timer_interrupt_flags;// Sticky flags
	reg  [2:0]  clock_source_select;  // This timer's source
	reg  [2:0]  second_clock_select;  // Sibling timer's source
	reg  [1:0]  count_mode;           // Counting sequence
	reg         count_down;           // Phase correct direction
	reg         compare_blocked;      // Set by a counter write

	// Bus state
	reg         aw_held;              // Write address captured
	reg  [5:0]  aw_addr;              // Captured write address
	reg         w_held;               // Write data captured
	reg  [31:0] w_data;               // Captured write data
	reg  [3:0]  w_strb;               // Captured byte enables

	// Internal pulses
	wire [3:0]  taps;                 // Prescaler tap pulses
	wire        ext_rise;             // Pin rising edge
	wire        ext_fall;             // Pin falling edge
	wire        second_rise;          // Second pin rising edge
	wire        second_fall;          // Second pin falling edge
	wire        do_write;             // Both halves of a write present
	wire [5:0]  wsel;                 // Write register selector
	wire [5:0]  rsel;                 // Read register selector
	wire        tick;                 // This timer's tick this cycle
	wire        prescaler_clear;      // Self-clearing reset strobe
	reg  [7:0]  next_counter;         // Counter after this tick
	reg         overflow_event;       // Overflow this cycle
	wire        compare_event;        // Qualified compare match this cycle
	reg  [31:0] read_word;            // Read multiplexer

	// Handshake readiness: one write and one read in flight
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign do_write      = aw_held && w_held && !s_axi_bvalid;
	assign wsel          = reg_decode(aw_addr);
	assign rsel          = reg_decode(s_axi_araddr);

	// Prescaler reset strobe exists for one cycle only, so it reads as zero
	assign prescaler_clear = do_write && wsel[5] && w_strb[0]
		&& w_data[`BIT_PRESCALER_RESET];

	// Shared prescaler for both timers
	tick_prescaler u_prescaler
	(
		.aclk            (aclk),
		.aresetn         (aresetn),
		.prescaler_clear (prescaler_clear),
		.tap_pulses      (taps)
	);

	// Edge detector for this timer's pin
	pin_edge_detect u_edge_main
	(
		.aclk       (aclk),
		.aresetn    (aresetn),
		.count_pin  (external_count_pin),
		.rise_pulse (ext_rise),
		.fall_pulse (ext_fall)
	);

	// Edge detector for the sibling timer's pin
	pin_edge_detect u_edge_second
	(
		.aclk       (aclk),
		.aresetn    (aresetn),
		.count_pin  (second_count_pin),
		.rise_pulse (second_rise),
		.fall_pulse (second_fall)
	);

	// Each timer picks its own tap from the same prescaler
	assign tick = pick_tick(clock_source_select, taps, ext_rise, ext_fall);

	// Tick enables registered for observation
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			timer_tick_enable  <= 1'b0;
			second_tick_enable <= 1'b0;
		end
		else
		begin
			timer_tick_enable  <= tick;
			second_tick_enable <= pick_tick(second_clock_select, taps,
				second_rise, second_fall);
		end
	end

	// Next counter value and overflow for the current mode
	always @*
	begin
		next_counter   = counter_value + 8'h01;
		overflow_event = 1'b0;
		case (count_mode)
			`MODE_PHASE_CORRECT:
			begin
				if (!count_down)
				begin
					// Turn around at the top without overflow
					if (counter_value == `COUNT_MAX)
						next_counter = counter_value - 8'h01;
				end
				else if (counter_value == `COUNT_BOTTOM)
				begin
					// Turn around at bottom, which is the overflow here
					overflow_event = 1'b1;
				end
				else
					next_counter = counter_value - 8'h01;
			end
			`MODE_CLEAR_ON_MATCH:
			begin
				// Restart after reaching the compare value
				if (counter_value == compare_value)
					next_counter = `COUNT_BOTTOM;
				overflow_event = counter_value == `COUNT_MAX;
			end
			default:
			begin
				// Normal and fast modes wrap at the maximum
				overflow_event = counter_value == `COUNT_MAX;
			end
		endcase
	end

	// Match is continuous; qualified by a tick and no recent counter write
	assign compare_event = tick && (counter_value == compare_value)
		&& !compare_blocked;

	// Counter, direction and write blocking
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			counter_value   <= `RST_COUNTER_VALUE;
			count_down      <= 1'b0;
			compare_blocked <= 1'b0;
		end
		else if (do_write && wsel[0] && w_strb[0])
		begin
			// Software write wins over a tick in the same cycle
			counter_value   <= w_data[7:0];
			compare_blocked <= 1'b1;
		end
		else if (tick)
		begin
			counter_value   <= next_counter;
			compare_blocked <= 1'b0;
			if (count_mode == `MODE_PHASE_CORRECT)
			begin
				// Direction flips at either end
				if (!count_down && counter_value == `COUNT_MAX)
					count_down <= 1'b1;
				else if (count_down && counter_value == `COUNT_BOTTOM)
					count_down <= 1'b0;
			end
			else
				count_down <= 1'b0;
		end
	end

	// Software-written configuration
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			compare_value        <= `RST_COMPARE_VALUE;
			timer_interrupt_mask <= `RST_IRQ_MASK;
			clock_source_select  <= `RST_CLOCK_SELECT;
			second_clock_select  <= `RST_CLOCK_SELECT;
			count_mode           <= `RST_MODE;
		end
		else if (do_write)
		begin
			if (wsel[1])
				compare_value <= merge_low(compare_value, w_data, w_strb);
			if (wsel[2])
				timer_interrupt_mask <= merge_low(timer_interrupt_mask, w_data, w_strb);
			if (wsel[4] && w_strb[0])
			begin
				clock_source_select <= w_data[`CS0_LSB +: 3];
				count_mode          <= w_data[`MODE_LSB +: 2];
			end
			if (wsel[4] && w_strb[1])
				second_clock_select <= w_data[`CS1_LSB +: 3];
		end
	end

	// Flags: hardware set wins over vector or software clear
	always @(posedge aclk)
	begin
		if (!aresetn)
			timer_interrupt_flags <= `RST_IRQ_FLAGS;
		else
		begin
			if (tick && overflow_event)
				timer_interrupt_flags[`BIT_OVERFLOW] <= 1'b1;
			else if (overflow_vector_taken)
				timer_interrupt_flags[`BIT_OVERFLOW] <= 1'b0;
			else if (do_write && wsel[3] && w_strb[0] && w_data[`BIT_OVERFLOW])
				timer_interrupt_flags[`BIT_OVERFLOW] <= 1'b0;
			if (compare_event)
				timer_interrupt_flags[`BIT_COMPARE] <= 1'b1;
			else if (compare_vector_taken)
				timer_interrupt_flags[`BIT_COMPARE] <= 1'b0;
			else if (do_write && wsel[3] && w_strb[0] && w_data[`BIT_COMPARE])
				timer_interrupt_flags[`BIT_COMPARE] <= 1'b0;
		end
	end

	// Interrupt requests and compare pin, registered
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			overflow_irq       <= 1'b0;
			compare_irq        <= 1'b0;
			compare_output_pin <= 1'b0;
		end
		else
		begin
			overflow_irq <= global_irq_enable
				&& timer_interrupt_mask[`BIT_OVERFLOW]
				&& timer_interrupt_flags[`BIT_OVERFLOW];
			compare_irq  <= global_irq_enable
				&& timer_interrupt_mask[`BIT_COMPARE]
				&& timer_interrupt_flags[`BIT_COMPARE];
			// Toggle on every qualified match
			if (compare_event)
				compare_output_pin <= ~compare_output_pin;
		end
	end

	// Write channel capture and response
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held      <= 1'b0;
			aw_addr      <= 6'h00;
			w_held       <= 1'b0;
			w_data       <= 32'h00000000;
			w_strb       <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `RESP_OKAY;
		end
		else
		begin
			// Address and data may arrive in either order
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write)
			begin
				// Unmapped addresses answer with a slave error
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (wsel == 6'h00) ? `RESP_SLVERR : `RESP_OKAY;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Read multiplexer; reserved bits and the strobe read as zero
	always @*
	begin
		read_word = 32'h00000000;
		case (1'b1)
			rsel[0]: read_word[7:0] = counter_value;
			rsel[1]: read_word[7:0] = compare_value;
			rsel[2]: read_word[7:0] = timer_interrupt_mask;
			rsel[3]: read_word[7:0] = timer_interrupt_flags;
			rsel[4]:
			begin
				read_word[`CS0_LSB +: 3]  = clock_source_select;
				read_word[`MODE_LSB +: 2] = count_mode;
				read_word[`CS1_LSB +: 3]  = second_clock_select;
			end
			default: read_word = 32'h00000000;
		endcase
	end

	// Read channel: answer one cycle after the address is taken
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= `RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= read_word;
			s_axi_rresp  <= (rsel == 6'h00) ? `RESP_SLVERR : `RESP_OKAY;
		end
		else if (s_axi_rvalid && s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

endmodule

// File: verification/count_pin_source.sv
// Purpose: External count source driving both timers' pins.
// Assumes: Called right after a rising edge of aclk.
// Notes:   Pins idle low and stand still between bursts.
`timescale 1ns/1ps
module count_pin_source
(
	// Clock
	input wire aclk,
	// Count pins
	output reg external_count_pin,
	output reg second_count_pin
);
	// Idle level at time zero
	initial
	begin
		external_count_pin = 1'b0;
		second_count_pin = 1'b0;
	end
	// Set this timer's pin and hold it one cycle
	task put(input v);
	begin
		external_count_pin <= v;
		@(posedge aclk);
	end
	endtask
	// Full periods, each half two system clocks, then settle quietly
	task pulse(input integer n);
	begin
		repeat (n)
		begin
			external_count_pin <= 1'b1;
			second_count_pin <= 1'b1;
			repeat (2) @(posedge aclk);
			external_count_pin <= 1'b0;
			second_count_pin <= 1'b0;
			repeat (2) @(posedge aclk);
		end
		repeat (4) @(posedge aclk);
	end
	endtask
endmodule

// File: verification/timer8_regs_monitor.sv
// Purpose: Port-level checks for the 8-bit timer register block.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Sees only the top ports; bound at the foot of this file.
`timescale 1ns/1ps
module timer8_regs_monitor
(
	// Clock and reset
	input wire        aclk,
	input wire        aresetn,
	// Bus handshakes
	input wire        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
	input wire        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
	input wire        s_axi_rvalid, s_axi_rready,
	// Bus payloads
	input wire [1:0]  s_axi_bresp,
	input wire [5:0]  s_axi_araddr,
	input wire [31:0] s_axi_rdata,
	input wire [1:0]  s_axi_rresp,
	// Core side and timer outputs
	input wire        global_irq_enable, overflow_vector_taken, compare_vector_taken,
	input wire        overflow_irq, compare_irq, timer_tick_enable, compare_output_pin
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Read data follows the taken address by one cycle
	property p_rd_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
	// Reads above the last register offset answer with an error code
	property p_rd_err;
		s_axi_arvalid && s_axi_arready && s_axi_araddr > 6'h14 |=> s_axi_rresp == 2'h2;
	endproperty
	a_rd_err: assert property (p_rd_err) else $error("unmapped read not refused");
	// Write answer within two cycles of both halves taken
	property p_wr_lat;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
	endproperty
	a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
	// Answers stand until taken
	property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped");
	property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
	// Interrupts need the global enable
	property p_ovf_irq; overflow_irq |-> $past(global_irq_enable); endproperty
	a_ovf_irq: assert property (p_ovf_irq) else $error("overflow irq without global");
	property p_cmp_irq; compare_irq |-> $past(global_irq_enable); endproperty
	a_cmp_irq: assert property (p_cmp_irq) else $error("compare irq without global");
	// A taken vector drops its request unless a new event lands
	property p_ovf_taken; overflow_vector_taken ##1 !timer_tick_enable |=> !overflow_irq; endproperty
	a_ovf_taken: assert property (p_ovf_taken) else $error("overflow irq kept");
	property p_cmp_taken; compare_vector_taken ##1 !timer_tick_enable |=> !compare_irq; endproperty
	a_cmp_taken: assert property (p_cmp_taken) else $error("compare irq kept");
	// Compare pin moves only with a counted tick
	property p_pin_tick; $changed(compare_output_pin) |-> timer_tick_enable; endproperty
	a_pin_tick: assert property (p_pin_tick) else $error("compare pin moved without tick");
endmodule

bind timer8_regs timer8_regs_monitor mon (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_bresp, .s_axi_araddr, .s_axi_rdata,
	.s_axi_rresp, .global_irq_enable, .overflow_vector_taken, .compare_vector_taken,
	.overflow_irq, .compare_irq, .timer_tick_enable, .compare_output_pin);

// File: verification/timer8_regs_tb_top.sv
// Purpose: Self-checking bench for the 8-bit timer register block.
// Assumes: 10 MHz clock, AXI4-Lite master tasks, pin source model.
// Notes:   Pin counting keeps counter values exact.
`timescale 1ns/1ps
module timer8_regs_tb_top;
	// Bus master drives
	logic        aclk = 1'b0, aresetn = 1'b0;
	logic [5:0]  s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	// Core side drives
	logic        global_irq_enable = 1'b0;
	logic        overflow_vector_taken = 1'b0, compare_vector_taken = 1'b0;
	// Design outputs and pins
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0]   s_axi_bresp, s_axi_rresp;
	wire [31:0]  s_axi_rdata;
	wire         overflow_irq, compare_irq, compare_output_pin;
	wire         timer_tick_enable, second_tick_enable, external_count_pin, second_count_pin;
	// Bookkeeping
	integer      err_count = 0, n_tests = 0, i, k;
	int          divs [4] = '{8, 64, 256, 1024};

	timer8_regs dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .global_irq_enable,
		.overflow_vector_taken, .compare_vector_taken, .overflow_irq, .compare_irq,
		.external_count_pin, .second_count_pin, .compare_output_pin, .timer_tick_enable,
		.second_tick_enable);
	count_pin_source pins (.aclk, .external_count_pin, .second_count_pin);

	// System clock, 100 ns period
	always #50 aclk = ~aclk;

	// Compare and count
	task chk(input [31:0] g, input [31:0] e);
	begin
		n_tests = n_tests + 1;
		if (g !== e)
		begin
			err_count = err_count + 1;
			$display("mismatch at %0t: got %h want %h", $time, g, e);
		end
	end
	endtask
	// Ready sampled at the falling edge equals its value at the next rising edge
	task wr(input [5:0] a, input [31:0] d, input [1:0] er);
		logic ta, tw, tb;
		logic [1:0] r;
	begin
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		tb = 1'b0;
		while (!tb)
		begin
			@(negedge aclk);
			ta = s_axi_awvalid & s_axi_awready;
			tw = s_axi_wvalid & s_axi_wready;
			tb = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
			if (ta)
				s_axi_awvalid <= 1'b0;
			if (tw)
				s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
		@(posedge aclk);
		chk(r, er);
	end
	endtask
	// Read one word and compare data and answer code
	task rd(input [5:0] a, input [31:0] e, input [1:0] er);
		logic ta, tv;
		logic [31:0] d;
		logic [1:0] r;
	begin
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		tv = 1'b0;
		while (!tv)
		begin
			@(negedge aclk);
			ta = s_axi_arvalid & s_axi_arready;
			tv = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (ta)
				s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
		@(posedge aclk);
		chk(d, e);
		chk(r, er);
	end
	endtask
	// Cycles until the chosen tick enable shows, bounded
	task ticks(input s, output integer n);
	begin
		n = 0;
		do
		begin
			@(negedge aclk);
			n = n + 1;
		end
		while (!(s ? second_tick_enable : timer_tick_enable) && n < 2100);
		@(posedge aclk);
	end
	endtask
	// Verdict and end of run
	task close_out;
	begin
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	end
	endtask

	// Hang guard at 20000 cycles, well beyond the expected run of under 4000 cycles
	initial
	begin
		#2000000;
		err_count = err_count + 1;
		$display("mismatch at %0t: watchdog expired", $time);
		close_out;
	end

	// Main sequence
	initial
	begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (i = 0; i < 6; i = i + 1)
			rd(6'(4 * i), 32'h0, 2'h0);
		rd(6'h18, 32'h0, 2'h2);
		wr(6'h18, 32'hff, 2'h2);
		// Byte lane 0 gates the low registers; lane 1 alone sets the sibling select
		s_axi_wstrb <= 4'he;
		wr(6'h04, 32'hff, 2'h0);
		rd(6'h04, 32'h0, 2'h0);
		s_axi_wstrb <= 4'h2;
		wr(6'h10, 32'h507, 2'h0);
		rd(6'h10, 32'h500, 2'h0);
		s_axi_wstrb <= 4'hf;
		// Direct clock run through a compare match
		wr(6'h04, 32'h03, 2'h0);
		wr(6'h08, 32'h01, 2'h0);
		global_irq_enable <= 1'b1;
		wr(6'h00, 32'h00, 2'h0);
		wr(6'h10, 32'h01, 2'h0);
		repeat (4) @(posedge aclk);
		wr(6'h10, 32'h00, 2'h0);
		rd(6'h0c, 32'h01, 2'h0);
		chk(compare_irq, 1'b1);
		chk(compare_output_pin, 1'b1);
		global_irq_enable <= 1'b0;
		repeat (2) @(posedge aclk);
		chk(compare_irq, 1'b0);
		global_irq_enable <= 1'b1;
		wr(6'h0c, 32'h00, 2'h0);
		rd(6'h0c, 32'h01, 2'h0);
		wr(6'h0c, 32'h01, 2'h0);
		rd(6'h0c, 32'h00, 2'h0);
		// A counter write hides the next match
		wr(6'h00, 32'h03, 2'h0);
		rd(6'h00, 32'h03, 2'h0);
		wr(6'h10, 32'h01, 2'h0);
		repeat (4) @(posedge aclk);
		wr(6'h10, 32'h00, 2'h0);
		rd(6'h0c, 32'h00, 2'h0);
		// Pin rising edges through an overflow
		wr(6'h00, 32'hfe, 2'h0);
		wr(6'h08, 32'h02, 2'h0);
		wr(6'h10, 32'h07, 2'h0);
		pins.pulse(3);
		rd(6'h00, 32'h01, 2'h0);
		rd(6'h0c, 32'h02, 2'h0);
		chk(overflow_irq, 1'b1);
		overflow_vector_taken <= 1'b1;
		compare_vector_taken <= 1'b1;
		@(posedge aclk);
		overflow_vector_taken <= 1'b0;
		compare_vector_taken <= 1'b0;
		repeat (2) @(posedge aclk);
		chk(overflow_irq, 1'b0);
		rd(6'h0c, 32'h00, 2'h0);
		// Falling edges count, then a stopped timer ignores the pin
		wr(6'h10, 32'h06, 2'h0);
		pins.pulse(2);
		rd(6'h00, 32'h03, 2'h0);
		wr(6'h10, 32'h00, 2'h0);
		pins.pulse(2);
		rd(6'h00, 32'h03, 2'h0);
		// Pin edge to counter step latency
		wr(6'h10, 32'h07, 2'h0);
		pins.put(1'b1);
		ticks(1'b0, k);
		chk(k, 3);
		pins.put(1'b0);
		// Clear on match restarts from zero after the compare value
		wr(6'h00, 32'h00, 2'h0);
		wr(6'h10, 32'h17, 2'h0);
		pins.pulse(5);
		rd(6'h00, 32'h01, 2'h0);
		// Phase correct: no flag at the top, flag at the bottom turn
		wr(6'h00, 32'hfd, 2'h0);
		wr(6'h0c, 32'h03, 2'h0);
		wr(6'h10, 32'h0f, 2'h0);
		pins.pulse(4);
		rd(6'h0c, 32'h00, 2'h0);
		wr(6'h00, 32'h02, 2'h0);
		pins.pulse(3);
		rd(6'h0c, 32'h02, 2'h0);
		// Every prescaler tap, sibling held on divide by 64
		for (i = 0; i < 4; i = i + 1)
		begin
			wr(6'h10, {21'h0, 3'h3, 5'h0, i[2:0] + 3'h2}, 2'h0);
			ticks(1'b0, k);
			ticks(1'b0, k);
			chk(k, divs[i]);
		end
		ticks(1'b1, k);
		ticks(1'b1, k);
		chk(k, 64);
		// Prescaler restart seen by both timers
		wr(6'h10, 32'h302, 2'h0);
		wr(6'h14, 32'h01, 2'h0);
		rd(6'h14, 32'h00, 2'h0);
		wr(6'h14, 32'h01, 2'h0);
		ticks(1'b0, k);
		chk(k >= 1 && k <= 9, 1'b1);
		ticks(1'b1, k);
		chk(k, 56);
		close_out;
	end
endmodule
